// >>> pkg/uss_regs.vh
// register offsets, field positions and reset values of the serial status/control block
`ifndef USS_REGS_VH
`define USS_REGS_VH

// ************************************************
// register offsets (byte addresses)
// ************************************************
`define USS_STATUS_CONTROL_OFF 4'h0
`define USS_LINE_CONFIG_OFF 4'h4

// ************************************************
// serial_status_control field positions
// ************************************************
`define USS_TX_IRQ_SELECT_HI 15
`define USS_TX_IDLE_POLARITY 14
`define USS_TX_IRQ_SELECT_LO 13
`define USS_UNUSED_BIT 12
`define USS_SEND_BREAK_REQUEST 11
`define USS_TX_ENABLE_BIT 10
`define USS_TX_BUFFER_FULL_FLAG 9
`define USS_TX_SHIFTER_EMPTY_FLAG 8
`define USS_RX_IRQ_SELECT_HI 7
`define USS_RX_IRQ_SELECT_LO 6
`define USS_ADDRESS_DETECT_ON 5
`define USS_RX_LINE_IDLE_FLAG 4
`define USS_PARITY_ERROR_FLAG 3
`define USS_FRAMING_ERROR_FLAG 2
`define USS_RX_OVERRUN_FLAG 1
`define USS_RX_DATA_AVAILABLE_FLAG 0

// line_config field positions
`define USS_INFRARED_ENCODE_ON 0

// ************************************************
// reset values
// ************************************************
`define USS_TX_IRQ_SELECT_RST 2'h0
`define USS_RX_IRQ_SELECT_RST 2'h0
`define USS_CTRL_BIT_RST 1'h0

// ************************************************
// mode encodings and buffer sizes
// ************************************************
`define USS_TXSEL_EACH_LOAD 2'h0
`define USS_TXSEL_ALL_DONE 2'h1
`define USS_TXSEL_BUF_EMPTY 2'h2
`define USS_TX_BUF_DEPTH 3'h4
`define USS_RX_BUF_FULL 3'h4
`define USS_RX_BUF_3Q 3'h3

// axi responses
`define USS_RESP_OKAY 2'h0
`define USS_RESP_DECERR 2'h3

`endif

// >>> design/uss_status_control.v
// serial transceiver status/control register with interrupt selection and pin steering
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "uss_regs.vh"

// Operation
// - mode 10: irq when load empties buffer
// - mode 01: irq when all transmission finished
// - mode 00: irq on each load; 11 reserved
// - encoding off: polarity set idles line low
// - encoding on: polarity set idles output high
// - break request sends break, hardware clears
// - enable hands transmit pin to transceiver
// - disable aborts, resets buffer, returns pin
// - read-only buffer full flag
// - shifter empty flag needs shifter and buffer
// - rx mode 11: irq at four characters
// - rx mode 10: irq at three characters
// - rx mode 0x: irq on every character
// - bit 12 always reads zero
module uss_status_control (
  // clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // axi4-lite write address and data
  input wire [3:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // axi4-lite read
  input wire [3:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // transmitter core
  input wire tx_load_in,
  input wire [2:0] tx_buf_count_in,
  input wire tx_shifter_busy_in,
  input wire tx_break_done_in,
  input wire tx_serial_in,
  input wire tx_encoded_in,
  input wire port_tx_in,
  output reg tx_enable_out,
  output reg tx_abort_out,
  output reg send_break_out,
  output reg serial_tx_pin_out,
  // receiver core
  input wire rx_xfer_in,
  input wire [2:0] rx_buf_count_in,
  input wire rx_line_idle_in,
  input wire parity_error_in,
  input wire framing_error_in,
  input wire rx_overrun_set_in,
  output reg address_detect_on_out,
  // interrupt pulses
  output reg tx_irq_out,
  output reg rx_irq_out
);

  // ************************************************
  // control state
  // ************************************************
  reg [1:0] tx_irq_select_q;
  reg tx_idle_polarity_q;
  reg send_break_request_q;
  reg tx_enable_bit_q;
  reg [1:0] rx_irq_select_q;
  reg address_detect_on_q;
  reg infrared_encode_on_q;
  reg rx_overrun_flag_q;
  reg shifter_empty_prev_q;
  reg aw_got_q;
  reg w_got_q;
  reg [3:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire tx_buffer_full_flag;
  wire tx_shifter_empty_flag;
  wire wr_fire;
  wire wr_status;
  wire wr_config;
  wire lane0;
  wire lane1;
  reg [15:0] status_word;
  reg [31:0] read_word;
  reg [1:0] read_resp;

  // ************************************************
  // buffer flags and write decode
  // ************************************************
  assign tx_buffer_full_flag = (tx_buf_count_in == `USS_TX_BUF_DEPTH);
  assign tx_shifter_empty_flag = !tx_shifter_busy_in
                                 && (tx_buf_count_in == 3'h0);
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid_out;
  assign wr_status = wr_fire && ({awaddr_q[3:2], 2'h0} == `USS_STATUS_CONTROL_OFF);
  assign wr_config = wr_fire && ({awaddr_q[3:2], 2'h0} == `USS_LINE_CONFIG_OFF);
  assign lane0 = wstrb_q[0];
  assign lane1 = wstrb_q[1];

  // ************************************************
  // read-back composition
  // ************************************************
  always @*
  begin
    status_word = 16'h0000;
    status_word[`USS_TX_IRQ_SELECT_HI] = tx_irq_select_q[1];
    status_word[`USS_TX_IDLE_POLARITY] = tx_idle_polarity_q;
    status_word[`USS_TX_IRQ_SELECT_LO] = tx_irq_select_q[0];
    status_word[`USS_UNUSED_BIT] = 1'b0;
    status_word[`USS_SEND_BREAK_REQUEST] = send_break_request_q;
    status_word[`USS_TX_ENABLE_BIT] = tx_enable_bit_q;
    status_word[`USS_TX_BUFFER_FULL_FLAG] = tx_buffer_full_flag;
    status_word[`USS_TX_SHIFTER_EMPTY_FLAG] = tx_shifter_empty_flag;
    status_word[`USS_RX_IRQ_SELECT_HI] = rx_irq_select_q[1];
    status_word[`USS_RX_IRQ_SELECT_LO] = rx_irq_select_q[0];
    status_word[`USS_ADDRESS_DETECT_ON] = address_detect_on_q;
    status_word[`USS_RX_LINE_IDLE_FLAG] = rx_line_idle_in;
    status_word[`USS_PARITY_ERROR_FLAG] = parity_error_in;
    status_word[`USS_FRAMING_ERROR_FLAG] = framing_error_in;
    status_word[`USS_RX_OVERRUN_FLAG] = rx_overrun_flag_q;
    status_word[`USS_RX_DATA_AVAILABLE_FLAG] = (rx_buf_count_in != 3'h0);
    read_word = 32'h0000_0000;
    read_resp = `USS_RESP_OKAY;
    case ({s_axi_araddr_in[3:2], 2'h0})
      `USS_STATUS_CONTROL_OFF: read_word = {16'h0000, status_word};
      `USS_LINE_CONFIG_OFF: read_word[`USS_INFRARED_ENCODE_ON] = infrared_encode_on_q;
      default: read_resp = `USS_RESP_DECERR;
    endcase
  end

  // ************************************************
  // axi4-lite write channel and control bits
  // ************************************************
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `USS_RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      tx_irq_select_q <= `USS_TX_IRQ_SELECT_RST;
      tx_idle_polarity_q <= `USS_CTRL_BIT_RST;
      send_break_request_q <= `USS_CTRL_BIT_RST;
      tx_enable_bit_q <= `USS_CTRL_BIT_RST;
      rx_irq_select_q <= `USS_RX_IRQ_SELECT_RST;
      address_detect_on_q <= `USS_CTRL_BIT_RST;
      infrared_encode_on_q <= `USS_CTRL_BIT_RST;
      rx_overrun_flag_q <= `USS_CTRL_BIT_RST;
      tx_abort_out <= 1'b0;
    end
    else
    begin
      tx_abort_out <= 1'b0;
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= (wr_status || wr_config) ? `USS_RESP_OKAY : `USS_RESP_DECERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in)
      begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
      if (wr_status && lane0)
      begin
        rx_irq_select_q <= wdata_q[`USS_RX_IRQ_SELECT_HI:`USS_RX_IRQ_SELECT_LO];
        address_detect_on_q <= wdata_q[`USS_ADDRESS_DETECT_ON];
      end
      if (wr_status && lane1)
      begin
        tx_irq_select_q <= {wdata_q[`USS_TX_IRQ_SELECT_HI], wdata_q[`USS_TX_IRQ_SELECT_LO]};
        tx_idle_polarity_q <= wdata_q[`USS_TX_IDLE_POLARITY];
        tx_enable_bit_q <= wdata_q[`USS_TX_ENABLE_BIT];
        // falling enable aborts the frame and empties the buffer
        if (tx_enable_bit_q && !wdata_q[`USS_TX_ENABLE_BIT])
          tx_abort_out <= 1'b1;
      end
      // break request: software set wins over hardware completion
      if (wr_status && lane1 && wdata_q[`USS_SEND_BREAK_REQUEST])
        send_break_request_q <= 1'b1;
      else if (tx_break_done_in)
        send_break_request_q <= 1'b0;
      // overrun: clear by writing zero, a new overrun wins
      if (rx_overrun_set_in)
        rx_overrun_flag_q <= 1'b1;
      else if (wr_status && lane0 && !wdata_q[`USS_RX_OVERRUN_FLAG])
        rx_overrun_flag_q <= 1'b0;
      if (wr_config && lane0)
        infrared_encode_on_q <= wdata_q[`USS_INFRARED_ENCODE_ON];
    end
  end

  // ************************************************
  // axi4-lite read channel
  // ************************************************
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `USS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= read_word;
        s_axi_rresp_out <= read_resp;
      end
      else if (s_axi_rvalid_out && s_axi_rready_in)
      begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // ************************************************
  // pin steering, interrupt pulses
  // ************************************************
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      serial_tx_pin_out <= 1'b1;
      tx_enable_out <= 1'b0;
      send_break_out <= 1'b0;
      address_detect_on_out <= 1'b0;
      tx_irq_out <= 1'b0;
      rx_irq_out <= 1'b0;
      shifter_empty_prev_q <= 1'b1;
    end
    else
    begin
      tx_enable_out <= tx_enable_bit_q;
      send_break_out <= send_break_request_q;
      address_detect_on_out <= address_detect_on_q;
      shifter_empty_prev_q <= tx_shifter_empty_flag;
      if (!tx_enable_bit_q)
        serial_tx_pin_out <= port_tx_in;
      else if (infrared_encode_on_q)
        serial_tx_pin_out <= tx_encoded_in ^ tx_idle_polarity_q;
      else
        serial_tx_pin_out <= tx_serial_in ^ tx_idle_polarity_q;
      // reserved select code stays silent
      case (tx_irq_select_q)
        `USS_TXSEL_EACH_LOAD: tx_irq_out <= tx_load_in;
        `USS_TXSEL_ALL_DONE: tx_irq_out <= tx_shifter_empty_flag
                                            && !shifter_empty_prev_q;
        `USS_TXSEL_BUF_EMPTY: tx_irq_out <= tx_load_in
                                             && (tx_buf_count_in == 3'h0);
        default: tx_irq_out <= 1'b0;
      endcase
      // any select with the high bit clear fires on every transfer
      case (rx_irq_select_q)
        2'h3: rx_irq_out <= rx_xfer_in
                            && (rx_buf_count_in == `USS_RX_BUF_FULL);
        2'h2: rx_irq_out <= rx_xfer_in
                            && (rx_buf_count_in == `USS_RX_BUF_3Q);
        default: rx_irq_out <= rx_xfer_in;
      endcase
    end
  end

endmodule

// >>> bench/uss_core_model.sv
// behavioural transmit and receive core beside the status/control block
`timescale 1ns/1ps
module uss_core_model #(parameter FRAME = 4'h8) (
  // clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // bench requests
  input wire push_in,
  input wire rx_push_in,
  input wire rx_drain_in,
  // from the block
  input wire tx_enable_in,
  input wire tx_abort_in,
  input wire send_break_in,
  // to the block
  output reg tx_load_out,
  output reg [2:0] tx_count_out,
  output wire tx_busy_out,
  output reg break_done_out,
  output wire serial_out,
  output wire encoded_out,
  output reg rx_xfer_out,
  output reg [2:0] rx_count_out
);
  reg [3:0] tmr_q;
  reg brk_q;
  wire go = tx_enable_in && tmr_q == 4'h0 && tx_count_out != 3'h0;
  assign tx_busy_out = tmr_q != 4'h0;
  // toggles inside a frame so a stale bit never looks idle
  assign serial_out = tx_busy_out ? tmr_q[0] : 1'h1;
  assign encoded_out = tx_busy_out ? tmr_q[0] : 1'h0;
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_count_out <= 3'h0;
      tmr_q <= 4'h0;
      brk_q <= 1'h0;
      tx_load_out <= 1'h0;
      break_done_out <= 1'h0;
      rx_xfer_out <= 1'h0;
      rx_count_out <= 3'h0;
    end
    else
    begin
      tx_load_out <= go;
      break_done_out <= brk_q && tmr_q == 4'h1;
      rx_xfer_out <= rx_push_in;
      rx_count_out <= rx_drain_in ? 3'h0 : rx_count_out + {2'h0, rx_push_in};
      if (tx_abort_in)
      begin
        // abort drops the frame and empties the buffer
        tx_count_out <= 3'h0;
        tmr_q <= 4'h0;
        brk_q <= 1'h0;
      end
      else
      begin
        tx_count_out <= tx_count_out + {2'h0, push_in} - {2'h0, go};
        if (go)
        begin
          tmr_q <= FRAME;
          brk_q <= send_break_in;
        end
        else if (tx_busy_out)
          tmr_q <= tmr_q - 4'h1;
      end
    end
  end
endmodule

// >>> bench/uss_status_control_sva.sv
// port-level assertions for the serial status/control block
`timescale 1ns/1ps
module uss_sva (
  // clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // read data
  input wire s_axi_rvalid_out,
  input wire [31:0] s_axi_rdata_out,
  // transmit and receive cores
  input wire tx_load_in,
  input wire [2:0] tx_buf_count_in,
  input wire tx_shifter_busy_in,
  input wire tx_break_done_in,
  input wire port_tx_in,
  input wire rx_xfer_in,
  // block outputs
  input wire tx_enable_out,
  input wire tx_abort_out,
  input wire send_break_out,
  input wire serial_tx_pin_out,
  input wire tx_irq_out,
  input wire rx_irq_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  a_tx_irq_once: assert property (tx_irq_out |=> !tx_irq_out)
    else $error("tx irq held too long");
  a_rx_irq_once: assert property (rx_irq_out |=> !rx_irq_out)
    else $error("rx irq held too long");
  a_rx_irq_cause: assert property (rx_irq_out |-> $past(rx_xfer_in))
    else $error("rx irq without transfer");
  a_tx_irq_cause: assert property (tx_irq_out |-> $past(tx_load_in) ||
    !$past(tx_shifter_busy_in) && $past(tx_buf_count_in) == 3'h0) else $error("tx irq no cause");
  a_pin_to_port: assert property (!tx_enable_out && $past(rst_n_in) |->
    serial_tx_pin_out == $past(port_tx_in)) else $error("pin not from port");
  a_abort_on_fall: assert property ($fell(tx_enable_out) |-> $past(tx_abort_out))
    else $error("no abort on disable");
  a_abort_once: assert property (tx_abort_out |-> tx_enable_out ##1
    !tx_enable_out && !tx_abort_out) else $error("bad abort pulse");
  a_break_clear: assert property ($fell(send_break_out) |->
    $past(tx_break_done_in, 2) || $past(tx_break_done_in)) else $error("break cleared early");
  a_bit12_zero: assert property (s_axi_rvalid_out |-> !s_axi_rdata_out[12])
    else $error("bit 12 not zero");
endmodule
bind uss_status_control uss_sva i_sva (.*);

// >>> bench/tb_top.sv
// self-checking bench of the serial status/control block
`timescale 1ns/1ps
`include "uss_regs.vh"
module tb_top;
  reg clock_in = 1'h0;
  reg rst_n_in = 1'h0;
  reg [3:0] s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0;
  reg [31:0] s_axi_wdata_in = 32'h0;
  reg s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
  reg s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, port_tx_in = 1'h1;
  reg push_q = 1'h0, rx_push_q = 1'h0, rx_drain_q = 1'h0;
  wire [3:0] s_axi_wstrb_in = 4'hF;
  wire rx_line_idle_in = 1'h1, parity_error_in = 1'h0, framing_error_in = 1'h0;
  wire rx_overrun_set_in = 1'h0;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  wire s_axi_rvalid_out, tx_load_in, tx_shifter_busy_in, tx_break_done_in, tx_serial_in;
  wire tx_encoded_in, rx_xfer_in, tx_enable_out, tx_abort_out, send_break_out;
  wire serial_tx_pin_out, address_detect_on_out, tx_irq_out, rx_irq_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire [2:0] tx_buf_count_in, rx_buf_count_in;
  integer err_total = 0, n_compared = 0, ntx = 0, nrx = 0, nab = 0, cyc = 0, m;
  reg [31:0] rd;
  reg [1:0] rr, rb;
  reg e;
  uss_status_control i_dut (.*);
  uss_core_model i_core (.clock_in(clock_in), .rst_n_in(rst_n_in), .push_in(push_q),
    .rx_push_in(rx_push_q), .rx_drain_in(rx_drain_q), .tx_enable_in(tx_enable_out),
    .tx_abort_in(tx_abort_out), .send_break_in(send_break_out), .tx_load_out(tx_load_in),
    .tx_count_out(tx_buf_count_in), .tx_busy_out(tx_shifter_busy_in),
    .break_done_out(tx_break_done_in), .serial_out(tx_serial_in), .encoded_out(tx_encoded_in),
    .rx_xfer_out(rx_xfer_in), .rx_count_out(rx_buf_count_in));
  initial forever #12.5 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    cyc = cyc + 1;
    if (tx_irq_out === 1'h1) ntx = ntx + 1;
    if (rx_irq_out === 1'h1) nrx = nrx + 1;
    if (tx_abort_out === 1'h1) nab = nab + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  task chk(input [8*10:1] nm, input [31:0] x, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== x)
      begin
        err_total = err_total + 1;
        $display("wrong value %0s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clock_in);
  endtask
  task axi_wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clock_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'h1;
      s_axi_wvalid_in <= 1'h1;
      s_axi_bready_in <= 1'h1;
      do
      begin
        @(posedge clock_in);
        if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
        if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
      end while (s_axi_bvalid_out !== 1'h1);
      rb = s_axi_bresp_out;
      s_axi_bready_in <= 1'h0;
    end
  endtask
  task axi_rd(input [3:0] a);
    begin
      @(posedge clock_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'h1;
      s_axi_rready_in <= 1'h1;
      do
      begin
        @(posedge clock_in);
        if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
      end while (s_axi_rvalid_out !== 1'h1);
      rd = s_axi_rdata_out;
      rr = s_axi_rresp_out;
      s_axi_rready_in <= 1'h0;
    end
  endtask
  // s 0: tx pushes back to back, 1: rx transfers spaced, 2: drain rx buffer
  task pulse(input integer s, input integer n);
    integer j;
    for (j = 0; j < n; j = j + 1)
    begin
      @(posedge clock_in);
      if (s == 0) push_q <= 1'h1;
      else if (s == 1) rx_push_q <= 1'h1;
      else rx_drain_q <= 1'h1;
      if (s != 0 || j == n - 1)
      begin
        @(posedge clock_in);
        push_q <= 1'h0;
        rx_push_q <= 1'h0;
        rx_drain_q <= 1'h0;
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial
  begin
    idle(16);
    rst_n_in <= 1'h1;
    axi_rd(4'h0);
    chk("status", 32'h0110, rd);
    $display("test reset done");
    for (m = 0; m < 3; m = m + 1)
    begin
      axi_wr(4'h0, {m[1], 1'h0, m[0], 13'h0400});
      ntx = 0;
      pulse(0, 3);
      idle(20);
      chk("tx irq mid", (m == 0) ? 3 : m - 1, ntx);
      idle(40);
      chk("tx irqs", (m == 0) ? 3 : 1, ntx);
    end
    $display("test tx modes done");
    pulse(0, 5);
    axi_rd(4'h0);
    chk("full", 1'h1, rd[9]);
    chk("empty", 1'h0, rd[8]);
    idle(60);
    axi_rd(4'h0);
    chk("full", 1'h0, rd[9]);
    chk("empty", 1'h1, rd[8]);
    $display("test flags done");
    axi_wr(4'h0, 32'h0);
    for (m = 0; m < 2; m = m + 1)
    begin
      port_tx_in <= m[0];
      idle(3);
      chk("port pin", m[0], serial_tx_pin_out);
    end
    for (m = 0; m < 4; m = m + 1)
    begin
      e = m[1] ? m[0] : !m[0];
      port_tx_in <= !e;
      axi_wr(4'h4, m[1]);
      axi_wr(4'h0, {m[0], 14'h0400});
      idle(3);
      chk("idle pin", e, serial_tx_pin_out);
    end
    axi_wr(4'h4, 32'h0);
    nab = 0;
    pulse(0, 1);
    idle(3);
    axi_wr(4'h0, 32'h0);
    idle(3);
    chk("aborts", 1, nab);
    chk("port pin", port_tx_in, serial_tx_pin_out);
    $display("test pin done");
    axi_wr(4'h0, 32'h0C00);
    axi_rd(4'h0);
    chk("break", 1'h1, rd[11]);
    pulse(0, 1);
    idle(20);
    axi_rd(4'h0);
    chk("break", 1'h0, rd[11]);
    $display("test break done");
    for (m = 0; m < 4; m = m + 1)
    begin
      pulse(2, 1);
      axi_wr(4'h0, {m[1:0], 6'h00});
      nrx = 0;
      pulse(1, 3);
      idle(3);
      chk("rx irq mid", (m < 2) ? 3 : 3 - m, nrx);
      pulse(1, 1);
      idle(3);
      chk("rx irqs", (m < 2) ? 4 : 1, nrx);
    end
    $display("test rx modes done");
    axi_wr(4'h0, 32'hFFFFDFFF);
    chk("bresp", `USS_RESP_OKAY, rb);
    axi_rd(4'h0);
    chk("status", 32'hCDF1, rd);
    chk("address_detect_on pin", 1'h1, address_detect_on_out);
    axi_wr(4'hC, 32'h0);
    chk("bresp", `USS_RESP_DECERR, rb);
    axi_rd(4'h0);
    chk("status", 32'hCDF1, rd);
    axi_rd(4'h8);
    chk("resp", `USS_RESP_DECERR, rr);
    chk("rdata", 32'h0, rd);
    $display("test registers done");
    tally_and_finish;
  end
endmodule
